// ---- iodrb_record_builder.sv ----
// Purpose: Builds the 16-byte extended diagnostic record of the digital
//          I/O technology functions and serves it over AXI4-Lite
// Assumes: Error and lost-event inputs come from logic on clk
// Notes:
// Notes on behaviour
// [RL1] Record is 16 bytes: basic 4 bytes, then 12 module-specific bytes.
// [RL2] Byte 4 bits 6..0 give channel type, here digital input 70h.
// [RL3] Byte 4 bit 7 set means further channel types follow.
// [RL4] Byte 5 holds diagnostic bits per channel, fixed 08h.
// [RL5] Byte 6 holds number of channels, fixed 08h.
// [RL6] Byte 7 bits 0..2 flag errors in input groups 0, 1, 2.
// [RL7] Frequency mode: byte 7 bits 4, 5 flag meter errors; 3, 6, 7 reserved.
// [RL8] Bytes 8..10 flag lost input interrupts on even bits; odd bits zero.
// [RL9] Frequency mode: bytes 12, 13 bit 0 flag lost integration-end interrupts.
// [RL10] PWM mode: byte 7 reports only groups 0..2; bits 7..3 reserved.
// [RL11] Byte 0: bit 0 module failure, bit 2 external, bit 3 channel error.
// [RL12] Byte 1: module class, channel-info bit; bytes 2, 3 read 00h.
// [RL13] Reserved bytes and bits read zero; lost flags stick until acknowledged.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none

module iodrb_record_builder (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,

    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,

    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,

    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,

    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,

    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,

    // Diagnostic conditions from the I/O logic
    input wire logic moduleFail,
    input wire logic externalErr,
    input wire logic [iodrb_pkg::NUM_GROUPS-1:0] groupErr,
    input wire logic [iodrb_pkg::NUM_METERS-1:0] meterErr,

    // Lost-interrupt events, one-cycle pulses
    input wire logic [iodrb_pkg::NUM_INPUTS-1:0] inputLostEv,
    input wire logic [iodrb_pkg::NUM_METERS-1:0] integLostEv,

    // Record towards the record-read logic
    output logic [127:0] diagRecord,
    output logic lostPending
);

    // ----------------------------------------
    // Write channel state
    // ----------------------------------------
    logic awHeld_r;
    logic awHeld_nxt;
    logic [4:0] awAddr_r;
    logic [4:0] awAddr_nxt;
    logic wHeld_r;
    logic wHeld_nxt;
    logic [31:0] wData_r;
    logic [31:0] wData_nxt;
    logic [3:0] wStrb_r;
    logic [3:0] wStrb_nxt;
    logic bValid_r;
    logic bValid_nxt;
    logic [1:0] bResp_r;
    logic [1:0] bResp_nxt;
    logic doWrite;
    logic wrCtrl;
    logic wrAck;

    assign s_axi_awready = !awHeld_r && !bValid_r;
    assign s_axi_wready = !wHeld_r && !bValid_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign doWrite = awHeld_r && wHeld_r && !bValid_r;
    assign wrCtrl = doWrite && (awAddr_r == iodrb_pkg::OFS_CTRL);
    assign wrAck = doWrite && (awAddr_r == iodrb_pkg::OFS_ACK);

    always_comb begin
        awHeld_nxt = awHeld_r;
        awAddr_nxt = awAddr_r;
        wHeld_nxt = wHeld_r;
        wData_nxt = wData_r;
        wStrb_nxt = wStrb_r;
        bValid_nxt = bValid_r;
        bResp_nxt = bResp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_nxt = 1'b1;
            awAddr_nxt = {s_axi_awaddr[4:2], 2'b00};
            if (s_axi_awaddr[31:5] != 27'h0) begin
                awAddr_nxt = 5'h1c;
            end
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_nxt = 1'b1;
            wData_nxt = s_axi_wdata;
            wStrb_nxt = s_axi_wstrb;
        end
        // Commit once both address and data are held
        if (doWrite) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt = (wrCtrl || wrAck) ? iodrb_pkg::RESP_OKAY : iodrb_pkg::RESP_SLVERR;
        end
        if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 5'h00;
            wHeld_r <= 1'b0;
            wData_r <= 32'h0;
            wStrb_r <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r <= 2'h0;
        end else begin
            awHeld_r <= awHeld_nxt;
            awAddr_r <= awAddr_nxt;
            wHeld_r <= wHeld_nxt;
            wData_r <= wData_nxt;
            wStrb_r <= wStrb_nxt;
            bValid_r <= bValid_nxt;
            bResp_r <= bResp_nxt;
        end
    end

    // ----------------------------------------
    // Diagnostic state
    // ----------------------------------------
    logic [2:0] ctrl_r;
    logic [2:0] ctrl_nxt;
    logic [iodrb_pkg::NUM_LOST-1:0] lost_r;
    logic [iodrb_pkg::NUM_LOST-1:0] lost_nxt;
    logic [127:0] record_r;
    logic [127:0] record_nxt;
    logic [iodrb_pkg::NUM_LOST-1:0] lostSet;
    logic [iodrb_pkg::NUM_LOST-1:0] lostClr;
    logic [15:0] ackMask;
    logic pwmMode;
    logic [23:0] inputLostBytes;
    logic [7:0] recByte [16];

    assign pwmMode = ctrl_r[iodrb_pkg::CTRL_PWM_BIT];
    assign ackMask = {{8{wStrb_r[1]}}, {8{wStrb_r[0]}}} & wData_r[15:0];

    // Spread the input flags onto even bit positions of bytes 8..10
    genvar gi;
    generate
        for (gi = 0; gi < iodrb_pkg::NUM_SLOTS; gi++) begin : g_slot
            // [RL8] Even-bit flags
            if (gi < iodrb_pkg::NUM_INPUTS) begin : g_used
                assign inputLostBytes[2*gi] = lost_r[gi];
            end else begin : g_free
                assign inputLostBytes[2*gi] = 1'b0;
            end
            assign inputLostBytes[2*gi+1] = 1'b0;
        end
    endgenerate

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wrCtrl && wStrb_r[0]) begin
            ctrl_nxt = wData_r[2:0];
        end
        // [RL9] Integration-end events count only in frequency mode
        lostSet = {integLostEv & {iodrb_pkg::NUM_METERS{!pwmMode}}, inputLostEv};
        lostClr = wrAck ? ackMask[iodrb_pkg::NUM_LOST-1:0] : '0;
        // [RL13] Sticky until acknowledged, set wins
        lost_nxt = (lost_r & ~lostClr) | lostSet;
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            recByte[i] = 8'h00;
        end
        // [RL6] Input group errors
        recByte[7][2:0] = groupErr;
        // [RL7] Meter errors in frequency mode
        // [RL10] PWM keeps bits 7..3 clear
        if (!pwmMode) begin
            recByte[7][5:4] = meterErr;
        end
        // [RL11] Basic status byte
        recByte[0][0] = moduleFail;
        recByte[0][2] = externalErr;
        recByte[0][3] = |recByte[7];
        // [RL12] Module class and channel info
        recByte[1][3:0] = iodrb_pkg::CLASS_DIGITAL;
        recByte[1][4] = ctrl_r[iodrb_pkg::CTRL_CHINFO_BIT];
        // [RL2] Channel type
        recByte[4][6:0] = iodrb_pkg::CH_TYPE_DIG_IN;
        // [RL3] Further channel types
        recByte[4][7] = ctrl_r[iodrb_pkg::CTRL_MORE_BIT];
        // [RL4] Bits per channel
        recByte[5] = iodrb_pkg::DIAG_BITS_PER_CH;
        // [RL5] Channel count
        recByte[6] = iodrb_pkg::NUM_CHANNELS;
        recByte[8] = inputLostBytes[7:0];
        recByte[9] = inputLostBytes[15:8];
        recByte[10] = inputLostBytes[23:16];
        // [RL9] Integration-end flags
        if (!pwmMode) begin
            recByte[12][0] = lost_r[iodrb_pkg::NUM_INPUTS];
            recByte[13][0] = lost_r[iodrb_pkg::NUM_INPUTS+1];
        end
        // [RL1] Pack 16 bytes little-endian
        for (int i = 0; i < 16; i++) begin
            record_nxt[8*i +: 8] = recByte[i];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= iodrb_pkg::CTRL_RESET;
            lost_r <= '0;
            record_r <= 128'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            lost_r <= lost_nxt;
            record_r <= record_nxt;
        end
    end

    assign diagRecord = record_r;

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    logic rValid_r;
    logic rValid_nxt;
    logic [31:0] rData_r;
    logic [31:0] rData_nxt;
    logic [1:0] rResp_r;
    logic [1:0] rResp_nxt;
    logic pend_r;

    assign s_axi_arready = !rValid_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;

    always_comb begin
        rValid_nxt = rValid_r;
        rData_nxt = rData_r;
        rResp_nxt = rResp_r;
        if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
            rData_nxt = 32'h0;
            rResp_nxt = iodrb_pkg::RESP_OKAY;
            if (s_axi_araddr[31:5] != 27'h0) begin
                rResp_nxt = iodrb_pkg::RESP_SLVERR;
            end else begin
                case (s_axi_araddr[4:0] & 5'h1c)
                    iodrb_pkg::OFS_REC0: rData_nxt = record_r[31:0];
                    iodrb_pkg::OFS_REC1: rData_nxt = record_r[63:32];
                    iodrb_pkg::OFS_REC2: rData_nxt = record_r[95:64];
                    iodrb_pkg::OFS_REC3: rData_nxt = record_r[127:96];
                    iodrb_pkg::OFS_CTRL: rData_nxt = {29'h0, ctrl_r};
                    iodrb_pkg::OFS_ACK: rData_nxt = {20'h0, lost_r};
                    default: rResp_nxt = iodrb_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rValid_r <= 1'b0;
            rData_r <= 32'h0;
            rResp_r <= 2'h0;
            pend_r <= 1'b0;
        end else begin
            rValid_r <= rValid_nxt;
            rData_r <= rData_nxt;
            rResp_r <= rResp_nxt;
            pend_r <= |lost_nxt;
        end
    end

    assign lostPending = pend_r;

endmodule : iodrb_record_builder

`default_nettype wire

// ---- iodrb_pkg.sv ----
// Purpose: Constants for the extended I/O diagnostic record builder
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Record bytes are packed little-endian, four to a word
`default_nettype none

package iodrb_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [4:0] OFS_REC0 = 5'h00;
    localparam logic [4:0] OFS_REC1 = 5'h04;
    localparam logic [4:0] OFS_REC2 = 5'h08;
    localparam logic [4:0] OFS_REC3 = 5'h0c;
    localparam logic [4:0] OFS_CTRL = 5'h10;
    localparam logic [4:0] OFS_ACK = 5'h14;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTRL_PWM_BIT = 0;
    localparam int CTRL_MORE_BIT = 1;
    localparam int CTRL_CHINFO_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h4;

    // ----------------------------------------
    // Lost-interrupt flag layout
    // ----------------------------------------
    localparam int NUM_INPUTS = 10;
    localparam int NUM_METERS = 2;
    localparam int NUM_LOST = NUM_INPUTS + NUM_METERS;
    localparam int NUM_GROUPS = 3;
    localparam int NUM_SLOTS = 12;

    // ----------------------------------------
    // Fixed record content
    // ----------------------------------------
    localparam logic [3:0] CLASS_ANALOG = 4'h5;
    localparam logic [3:0] CLASS_DIGITAL = 4'hf;
    localparam logic [6:0] CH_TYPE_DIG_IN = 7'h70;
    localparam logic [6:0] CH_TYPE_ANA_IN = 7'h71;
    localparam logic [6:0] CH_TYPE_DIG_OUT = 7'h72;
    localparam logic [6:0] CH_TYPE_ANA_OUT = 7'h73;
    localparam logic [6:0] CH_TYPE_ANA_IO = 7'h74;
    localparam logic [7:0] DIAG_BITS_PER_CH = 8'h08;
    localparam logic [7:0] NUM_CHANNELS = 8'h08;

    // ----------------------------------------
    // Bus responses
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : iodrb_pkg

`default_nettype wire

// ---- iodrb_chk_assertions.sv ----
// Purpose: Port-level checks of the diagnostic record builder
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound to the builder below the module
`default_nettype none

module iodrb_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Conditions
    input wire logic moduleFail,
    input wire logic externalErr,
    input wire logic [iodrb_pkg::NUM_GROUPS-1:0] groupErr,
    input wire logic [iodrb_pkg::NUM_METERS-1:0] meterErr,
    input wire logic [iodrb_pkg::NUM_INPUTS-1:0] inputLostEv,
    // Record
    input wire logic [127:0] diagRecord,
    input wire logic lostPending
);
    localparam logic [127:0] RSV = 128'hffff_fefe_fffa_aaaa_c800_0000_ffff_e0f2;
    logic [1:0] upCnt_r;
    logic [1:0] upCnt_nxt;
    logic up;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Record is live a few edges after reset
    always_comb begin
        upCnt_nxt = (upCnt_r == 2'h3) ? upCnt_r : upCnt_r + 2'h1;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            upCnt_r <= 2'h0;
        end else begin
            upCnt_r <= upCnt_nxt;
        end
    end
    assign up = (upCnt_r == 2'h3);

    sequence s_lostSeen;
        lostPending ##1 diagRecord[82];
    endsequence

    property p_fixed;
        up |-> diagRecord[38:32] == 7'h70 && diagRecord[55:40] == 16'h0808 && diagRecord[11:8] == 4'hf;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed record field wrong");
    property p_rsvd;
        up |-> (diagRecord & RSV) == 128'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved record bit set");
    property p_group;
        up |-> diagRecord[58:56] == $past(groupErr);
    endproperty
    a_group: assert property (p_group)
        else $error("group error bits wrong");
    property p_meter;
        up |-> diagRecord[61:60] == 2'h0 || diagRecord[61:60] == $past(meterErr);
    endproperty
    a_meter: assert property (p_meter)
        else $error("meter error bits wrong");
    property p_basic;
        up |-> diagRecord[0] == $past(moduleFail) && diagRecord[2] == $past(externalErr)
            && diagRecord[3] == |diagRecord[63:56];
    endproperty
    a_basic: assert property (p_basic)
        else $error("basic byte wrong");
    property p_lost;
        up && inputLostEv[9] |=> s_lostSeen;
    endproperty
    a_lost: assert property (p_lost)
        else $error("lost input flag missing");
    property p_sticky;
        $fell(lostPending) |-> $rose(s_axi_bvalid);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("lost flags cleared without write");
    property p_rdAns;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rdAns: assert property (p_rdAns)
        else $error("read answer late");
    property p_bHold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bHold: assert property (p_bHold)
        else $error("write response dropped");
endmodule : iodrb_chk

bind iodrb_record_builder iodrb_chk u_chk (.clk, .sys_rst, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .moduleFail, .externalErr,
    .groupErr, .meterErr, .inputLostEv, .diagRecord, .lostPending);

`default_nettype wire

// ---- iodrb_rec_reader.sv ----
// Purpose: Record-read logic model on the consumer side
// Assumes: Same clock as the builder
// Notes:   Picks one record byte from a sampled copy
`default_nettype none

module iodrb_rec_reader (
    // Clock
    input wire logic clk,
    // Record from the builder
    input wire logic [127:0] diagRecord,
    // Byte select and result
    input wire logic [3:0] byteSel,
    output logic [7:0] recByte
);
    logic [127:0] shadow_r;

    always_ff @(posedge clk) begin
        shadow_r <= diagRecord;
    end
    assign recByte = shadow_r[{byteSel, 3'h0} +: 8];
endmodule : iodrb_rec_reader

`default_nettype wire

// ---- iodrb_record_builder_tb.sv ----
// Purpose: Self-checking bench of the diagnostic record builder
// Assumes: 10 MHz clock, bus master per AXI4-Lite
// Notes:   Expected words are built from the byte layout
`default_nettype none

module iodrb_record_builder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, sys_rst = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, groupErr = '0;
    logic [3:0] s_axi_wstrb = 4'hf, byteSel = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, meterErr = '0, integLostEv = '0;
    logic moduleFail = 1'b0, externalErr = 1'b0, lostPending;
    logic [9:0] inputLostEv = '0;
    logic [127:0] diagRecord;
    logic [7:0] recByte;
    int n_fail = 0, n_compared = 0;

    always #50 clk = ~clk;

    iodrb_record_builder dut (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .moduleFail, .externalErr,
        .groupErr, .meterErr, .inputLostEv, .integLostEv, .diagRecord, .lostPending);
    iodrb_rec_reader u_rdr (.clk, .diagRecord, .byteSel, .recByte);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic tA, tW, tB;
        tB = 1'b0;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!tB) begin
            @(negedge clk);
            tA = s_axi_awvalid && s_axi_awready;
            tW = s_axi_wvalid && s_axi_wready;
            tB = s_axi_bvalid && s_axi_bready;
            if (tB) chk({30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge clk);
            if (tA) s_axi_awvalid <= 1'b0;
            if (tW) s_axi_wvalid <= 1'b0;
            if (tB) s_axi_bready <= 1'b0;
        end
        // Let the release settle before the next request drives the same strobes
        @(posedge clk);
    endtask : wr

    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        logic tA, tR;
        tR = 1'b0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        while (!tR) begin
            @(negedge clk);
            tA = s_axi_arvalid && s_axi_arready;
            tR = s_axi_rvalid && s_axi_rready;
            if (tR) chk(s_axi_rdata, exp);
            if (tR) chk({30'h0, s_axi_rresp}, (a < 32'h18) ? 32'h0 : {30'h0, iodrb_pkg::RESP_SLVERR});
            @(posedge clk);
            if (tA) s_axi_arvalid <= 1'b0;
            if (tR) s_axi_rready <= 1'b0;
        end
        @(posedge clk);
    endtask : rc

    task automatic t_idle();
        rc(32'h00, 32'h0000_1f00);
        rc(32'h04, 32'h0008_0870);
        rc(32'h08, 32'h0);
        rc(32'h0c, 32'h0);
        rc(32'h10, {29'h0, iodrb_pkg::CTRL_RESET});
    endtask : t_idle

    task automatic t_err();
        moduleFail <= 1'b1;
        externalErr <= 1'b1;
        groupErr <= 3'h5;
        meterErr <= 2'h2;
        byteSel <= 4'h7;
        // Record register lags the conditions by one edge
        @(posedge clk);
        rc(32'h00, 32'h0000_1f0d);
        rc(32'h04, 32'h2508_0870);
        @(negedge clk);
        chk({24'h0, recByte}, 32'h25);
        @(posedge clk);
        wr(32'h10, 32'h3, iodrb_pkg::RESP_OKAY);
        rc(32'h00, 32'h0000_0f0d);
        rc(32'h04, 32'h0508_08f0);
        integLostEv <= 2'h3;
        @(posedge clk);
        integLostEv <= 2'h0;
        repeat (2) @(posedge clk);
        rc(32'h0c, 32'h0);
        rc(32'h14, 32'h0);
        wr(32'h10, 32'h4, iodrb_pkg::RESP_OKAY);
        moduleFail <= 1'b0;
        externalErr <= 1'b0;
        groupErr <= 3'h0;
        meterErr <= 2'h0;
    endtask : t_err

    task automatic t_lost();
        inputLostEv <= 10'h201;
        integLostEv <= 2'h2;
        @(posedge clk);
        inputLostEv <= 10'h0;
        integLostEv <= 2'h0;
        repeat (3) @(posedge clk);
        rc(32'h08, 32'h0004_0001);
        rc(32'h0c, 32'h0000_0100);
        rc(32'h14, 32'h0000_0a01);
        @(negedge clk);
        chk({31'h0, lostPending}, 32'h1);
        @(posedge clk);
        wr(32'h14, 32'h0000_0a01, iodrb_pkg::RESP_OKAY);
        rc(32'h08, 32'h0);
        rc(32'h0c, 32'h0);
        @(negedge clk);
        chk({31'h0, lostPending}, 32'h0);
        @(posedge clk);
    endtask : t_lost

    task automatic t_bus();
        rc(32'h18, 32'h0);
        wr(32'h00, 32'hffff_ffff, iodrb_pkg::RESP_SLVERR);
        rc(32'h00, 32'h0000_1f00);
    endtask : t_bus

    task automatic summarize();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        #300000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_idle();
        t_err();
        t_lost();
        t_bus();
        summarize();
    end
endmodule : iodrb_record_builder_tb

`default_nettype wire
